/* File: src/lsis_top.sv */
// Mode control, status register and interrupt logic of the link slave
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module lsis_top
  import lsis_pkg::*;
#(
  parameter int FILT_LEN = RX_FILT_LEN
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Link pin and protocol engine
  input  wire logic       RX_PIN,
  input  wire lsis_evt_t  EVT,
  input  wire logic [7:0] PROTO_VECTOR,
  // Mode outputs
  output logic            LINK_CLK_EN,
  output logic            RUN_MODE,
  output logic            IRQ
);

  // ====================================================================
  // Receive pin synchroniser and digital filter
  // The pin is asynchronous, so only rx_s2_ff feeds the filter; rx_s1_ff may
  // still be settling. Reset values are recessive so no false edge follows reset.
  // A dominant pulse shorter than FILT_LEN cycles never reaches the filter output.
  logic                rx_s1_ff, rx_s2_ff, rx_filt_ff, nxt_rx_filt;
  logic [FILT_LEN-1:0] rx_hist_ff, nxt_rx_hist;
  logic                fall_edge;

  always_comb begin
    nxt_rx_hist = {rx_hist_ff[FILT_LEN-2:0], rx_s2_ff};
    nxt_rx_filt = rx_filt_ff;
    if (&rx_hist_ff) begin
      nxt_rx_filt = 1'b1;
    end else if (~|rx_hist_ff) begin
      nxt_rx_filt = 1'b0;
    end
  end

  // Filter holds its last level until the pin is stable for FILT_LEN cycles
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_s1_ff   <= 1'b1;
      rx_s2_ff   <= 1'b1;
      rx_hist_ff <= '1;
      rx_filt_ff <= 1'b1;
    end else begin
      rx_s1_ff   <= RX_PIN;
      rx_s2_ff   <= rx_s1_ff;
      rx_hist_ff <= nxt_rx_hist;
      rx_filt_ff <= nxt_rx_filt;
    end
  end

  // Edge taken from the next filter value so the semaphore sets one cycle sooner
  assign fall_edge = rx_filt_ff & ~nxt_rx_filt;

  // ====================================================================
  // Register decode
  // Reads have no side effect except on the sticky event register
  // Writes to unmapped or read-only indices fall through and are ignored
  logic wr_ctrl, wr_status, wr_mask, wr_wonce, rd_evt;
  assign wr_ctrl   = WR && (ADDR == LSIS_ADDR_CTRL);
  assign wr_status = WR && (ADDR == LSIS_ADDR_STATUS);
  assign wr_mask   = WR && (ADDR == LSIS_ADDR_MASK);
  assign wr_wonce  = WR && (ADDR == LSIS_ADDR_WONCE);
  assign rd_evt    = RD && (ADDR == LSIS_ADDR_EVT);

  // ====================================================================
  // Mode state machine and control bits
  lsis_mode_t mode_ff, nxt_mode;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic       wonce_ff, nxt_wonce, wonce_done_ff, nxt_wonce_done;
  logic       ack;

  // Acknowledge follows the request bit while in reset mode; a system reset
  // leaves the request set, so software sees it until the request is cleared
  assign ack = (mode_ff == LSIS_RESET) && ctrl_ff[CTRL_REQ_BIT];

  always_comb begin
    nxt_ctrl       = ctrl_ff;
    nxt_wonce      = wonce_ff;
    nxt_wonce_done = wonce_done_ff;
    nxt_mode       = mode_ff;
    if (wr_ctrl) begin
      if (ack) begin
        // Only the request bit listens while acknowledged; rest stays reset
        nxt_ctrl = CTRL_RESET & 8'hfe;
        nxt_ctrl[CTRL_REQ_BIT] = WDATA[CTRL_REQ_BIT];
      end else begin
        nxt_ctrl = WDATA & CTRL_MASK;
      end
    end
    // Write-once bit is exempt from the acknowledge hold
    if (wr_wonce && !wonce_done_ff) begin
      nxt_wonce      = WDATA[0];
      nxt_wonce_done = 1'b1;
    end
    // Mode moves look at the next control value so a write acts at the very
    // next edge; run is only ever reached through the disabled mode
    case (mode_ff)
      LSIS_RESET: begin
        if (!nxt_ctrl[CTRL_REQ_BIT]) begin
          nxt_mode = LSIS_DISABLED;
        end
      end
      LSIS_DISABLED: begin
        if (nxt_ctrl[CTRL_REQ_BIT]) begin
          nxt_mode = LSIS_RESET;
        end else if (nxt_ctrl[CTRL_EN_BIT]) begin
          nxt_mode = LSIS_RUN;
        end
      end
      LSIS_RUN: begin
        if (nxt_ctrl[CTRL_REQ_BIT]) begin
          nxt_mode = LSIS_RESET;
        end else if (!nxt_ctrl[CTRL_EN_BIT]) begin
          nxt_mode = LSIS_DISABLED;
        end
      end
      default: nxt_mode = LSIS_RESET;
    endcase
    // Entering or staying in reset mode snaps control back to its reset value
    if (nxt_mode == LSIS_RESET) begin
      nxt_ctrl = CTRL_RESET;
    end
  end

  // System reset, including power-up, forces reset mode at once
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode_ff       <= LSIS_RESET;
      ctrl_ff       <= CTRL_RESET;
      wonce_ff      <= 1'b0;
      wonce_done_ff <= 1'b0;
    end else begin
      mode_ff       <= nxt_mode;
      ctrl_ff       <= nxt_ctrl;
      wonce_ff      <= nxt_wonce;
      wonce_done_ff <= nxt_wonce_done;
    end
  end

  // Engine clock gate request: low in reset mode
  // Limitation: this only requests the gate; the clock cell sits outside
  assign LINK_CLK_EN = (mode_ff != LSIS_RESET);
  assign RUN_MODE    = (mode_ff == LSIS_RUN);

  // ====================================================================
  // Status bits: activity semaphore, pending flag, state vector
  // The semaphore is only meaningful in run mode; in bit-time measurement
  // mode software must ignore it, so no special case is made for that mode
  logic       act_ff, nxt_act, flag_ff, nxt_flag;
  logic [7:0] sv_ff, nxt_sv;
  logic       any_src, done_evt, run;

  assign run      = (mode_ff == LSIS_RUN);
  assign any_src  = run && (EVT.rx_full_ok || EVT.tx_empty_ok || EVT.other_irq);
  assign done_evt = run && (EVT.rx_full_ok || EVT.tx_empty_ok);

  always_comb begin
    nxt_act  = act_ff;
    nxt_flag = flag_ff;
    nxt_sv   = sv_ff;
    // Completion clears; a fresh edge in the same cycle wins and sets again
    if (done_evt) begin
      nxt_act = 1'b0;
    end
    if (run && fall_edge) begin
      nxt_act = 1'b1;
    end
    // Only a one in bit 0 clears; other status writes are dropped
    if (wr_status && WDATA[STS_FLAG_BIT]) begin
      nxt_flag = 1'b0;
    end
    if (any_src) begin
      nxt_flag = 1'b1;
    end
    if (EVT.rx_full_ok) begin
      nxt_sv = SV_RX_FULL;
    end else if (EVT.tx_empty_ok) begin
      nxt_sv = SV_TX_EMPTY;
    end else if (any_src) begin
      nxt_sv = PROTO_VECTOR;
    end
    if (mode_ff == LSIS_RESET) begin
      nxt_act  = 1'b0;
      nxt_flag = 1'b0;
      nxt_sv   = SV_NONE;
    end
  end

  // Status registers, cleared by any system reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      act_ff  <= 1'b0;
      flag_ff <= 1'b0;
      sv_ff   <= SV_NONE;
    end else begin
      act_ff  <= nxt_act;
      flag_ff <= nxt_flag;
      sv_ff   <= nxt_sv;
    end
  end

  // ====================================================================
  // Sticky event status, read-to-clear, with mask
  logic [EVT_NUM-1:0] evt_ff, nxt_evt, mask_ff, nxt_mask, evt_in;
  logic               ack_dly_ff;

  assign evt_in[EVT_EDGE_BIT] = run && fall_edge;
  assign evt_in[EVT_RX_BIT]   = run && EVT.rx_full_ok;
  assign evt_in[EVT_TX_BIT]   = run && EVT.tx_empty_ok;
  assign evt_in[EVT_ACK_BIT]  = ack & ~ack_dly_ff;

  // Set wins over the read-clear so no event is lost
  // Mask belongs to the register set, so it is held cleared while the
  // acknowledge is up; the sticky bits still record the acknowledge rise
  always_comb begin
    nxt_mask = mask_ff;
    if (ack) begin
      nxt_mask = '0;
    end else if (wr_mask) begin
      nxt_mask = WDATA[EVT_NUM-1:0];
    end
    nxt_evt  = (rd_evt ? '0 : evt_ff) | evt_in;
  end

  // Event, mask and acknowledge-delay registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_ff     <= '0;
      mask_ff    <= '0;
      ack_dly_ff <= 1'b1; // Matches ack after reset, so no false rise
    end else begin
      evt_ff     <= nxt_evt;
      mask_ff    <= nxt_mask;
      ack_dly_ff <= ack;
    end
  end

  // Level output: stays high until the flag is cleared and the events read
  assign IRQ = flag_ff | (|(evt_ff & mask_ff));

  // ====================================================================
  // Read data, one cycle after the read strobe
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        LSIS_ADDR_CTRL: nxt_rdata = ctrl_ff;
        LSIS_ADDR_STATUS: begin
          nxt_rdata[STS_ACT_BIT]  = act_ff;
          nxt_rdata[STS_ACK_BIT]  = ack;
          nxt_rdata[STS_FLAG_BIT] = flag_ff;
        end
        LSIS_ADDR_VECTOR: nxt_rdata = sv_ff;
        LSIS_ADDR_EVT:    nxt_rdata = {{(8-EVT_NUM){1'b0}}, evt_ff};
        LSIS_ADDR_MASK:   nxt_rdata = {{(8-EVT_NUM){1'b0}}, mask_ff};
        LSIS_ADDR_WONCE:  nxt_rdata = {7'h00, wonce_ff};
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  // Zero outside a read cycle so the bus side can OR-combine read data
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;

endmodule

/* File: src/lsis_pkg.sv */
// Package with register map, field positions and state types for the link mode/status block
package lsis_pkg;

  // ====================================================================
  // Register indices (one byte register per address)
  localparam logic [3:0] LSIS_ADDR_CTRL   = 4'h0; // Control: request, enable, config
  localparam logic [3:0] LSIS_ADDR_STATUS = 4'h1; // link_status
  localparam logic [3:0] LSIS_ADDR_VECTOR = 4'h2; // state_vector
  localparam logic [3:0] LSIS_ADDR_EVT    = 4'h3; // Sticky event status
  localparam logic [3:0] LSIS_ADDR_MASK   = 4'h4; // Event mask
  localparam logic [3:0] LSIS_ADDR_WONCE  = 4'h5; // Write-once configuration

  // ====================================================================
  // Control register fields
  localparam int CTRL_REQ_BIT  = 0; // reset_mode_request
  localparam int CTRL_EN_BIT   = 1; // module_enable_bit
  localparam int CTRL_BTM_BIT  = 2; // bit_time_measure_mode
  localparam int CTRL_IGNORE_MESSAGE_BIT_BIT = 3; // ignore_message_bit
  localparam logic [7:0] CTRL_RESET = 8'h01; // Request set out of reset
  localparam logic [7:0] CTRL_MASK  = 8'h0f;

  // ====================================================================
  // link_status fields
  localparam int STS_ACT_BIT  = 7;
  localparam int STS_ACK_BIT  = 5;
  localparam int STS_FLAG_BIT = 0;

  // ====================================================================
  // State vector codes of the two completion sources
  localparam logic [7:0] SV_NONE     = 8'h00;
  localparam logic [7:0] SV_TX_EMPTY = 8'h08;
  localparam logic [7:0] SV_RX_FULL  = 8'h10;

  // ====================================================================
  // Event status / mask fields
  localparam int EVT_EDGE_BIT = 0;
  localparam int EVT_RX_BIT   = 1;
  localparam int EVT_TX_BIT   = 2;
  localparam int EVT_ACK_BIT  = 3;
  localparam int EVT_NUM      = 4;

  // ====================================================================
  // Receive filter length in cycles
  localparam int RX_FILT_LEN = 4;

  // ====================================================================
  // Operating modes
  typedef enum logic [2:0] {
    LSIS_RESET    = 3'b001,
    LSIS_DISABLED = 3'b010,
    LSIS_RUN      = 3'b100
  } lsis_mode_t;

  // Completion and other interrupt events from the protocol engine
  typedef struct packed {
    logic rx_full_ok;
    logic tx_empty_ok;
    logic other_irq;
  } lsis_evt_t;

endpackage

/* File: testbench/lsis_props.sv */
// Checker of the link mode/status block ports
`timescale 1ns/1ps
module lsis_props
  import lsis_pkg::*;
(
  // Clock, reset and register port
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Engine events and mode outputs
  input wire lsis_evt_t  EVT,
  input wire logic       LINK_CLK_EN,
  input wire logic       RUN_MODE,
  input wire logic       IRQ
);
  // ==================================================================
  // Mode sequencing and status; all on CLK, off during reset
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_POR_HOLD: assert property ($past(RESET) |-> !LINK_CLK_EN && !RUN_MODE)
    else $error("mode left reset at once");
  AST_CLK_STOP: assert property (!LINK_CLK_EN |-> !RUN_MODE)
    else $error("run while clocks stopped");
  AST_RUN_VIA_DIS: assert property ($rose(RUN_MODE) |-> $past(LINK_CLK_EN))
    else $error("run entered straight from reset");
  AST_DIS_FIRST: assert property ($rose(LINK_CLK_EN) |-> !RUN_MODE)
    else $error("reset left without disabled step");
  AST_REQ_ENTER: assert property (WR && ADDR == LSIS_ADDR_CTRL && WDATA[CTRL_REQ_BIT]
    |-> ##[1:2] !LINK_CLK_EN) else $error("request did not stop clocks");
  AST_ACK_RUN: assert property (RD && ADDR == LSIS_ADDR_STATUS && RUN_MODE && !$past(WR)
    |=> !RDATA[STS_ACK_BIT]) else $error("acknowledge set in run");
  AST_FLAG_IRQ: assert property ((RD && ADDR == LSIS_ADDR_STATUS) ##1 RDATA[STS_FLAG_BIT]
    |-> $past(IRQ)) else $error("pending flag without interrupt");
  AST_EVT_IRQ: assert property (RUN_MODE && (|EVT) |=> IRQ)
    else $error("event left no interrupt");
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read cycle");
  AST_RESET_QUIET: assert property (!LINK_CLK_EN && !$past(LINK_CLK_EN) |-> !IRQ)
    else $error("interrupt raised in reset mode");
  // Main scenarios reached
  cover property ($rose(RUN_MODE));
  cover property (EVT.rx_full_ok && RUN_MODE);
  cover property (RD && ADDR == LSIS_ADDR_VECTOR);
endmodule

bind lsis_top lsis_props lsis_props_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EVT(EVT),
  .LINK_CLK_EN(LINK_CLK_EN), .RUN_MODE(RUN_MODE), .IRQ(IRQ));

/* File: testbench/lsis_lin_master.sv */
// Master node stand-in that drives the receive pin
`timescale 1ns/1ps
module lsis_lin_master #(
  parameter int BREAK_LEN = 16
) (
  // Clock and command
  input  wire logic clk,
  input  wire logic send,
  // Bus side
  output logic      rx_pin,
  output logic      busy
);
  int cnt = 0;
  // Dominant break of fixed length; a new send is dropped while busy
  always_ff @(posedge clk) begin
    if (send && cnt == 0)
      cnt <= BREAK_LEN;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  // Pull-up holds the line recessive between frames
  assign rx_pin = (cnt == 0);
  assign busy   = (cnt != 0);
endmodule

/* File: testbench/tb_lsis_top.sv */
// Self-checking bench of the link mode/status block
`timescale 1ns/1ps
module tb_lsis_top;
  import lsis_pkg::*;
  typedef struct {logic r; logic [3:0] a; logic [7:0] d;} lsis_row_t;
  logic       clk, reset, wr, rd, rx, send, clk_en, run, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, pvec, got;
  lsis_evt_t  evt;
  int         error_cnt, checks_done;
  // Register table: reads carry the expected value
  lsis_row_t  rows[13] = '{
    '{1, LSIS_ADDR_STATUS, 8'h20}, '{0, LSIS_ADDR_CTRL, 8'h0f}, '{1, LSIS_ADDR_CTRL, 8'h01},
    '{0, LSIS_ADDR_WONCE, 8'h01}, '{0, LSIS_ADDR_CTRL, 8'h00}, '{1, LSIS_ADDR_WONCE, 8'h01},
    '{1, LSIS_ADDR_STATUS, 8'h00}, '{0, LSIS_ADDR_CTRL, 8'h02}, '{0, LSIS_ADDR_MASK, 8'h0f},
    '{1, LSIS_ADDR_CTRL, 8'h02}, '{0, LSIS_ADDR_WONCE, 8'h00}, '{1, LSIS_ADDR_WONCE, 8'h01},
    '{1, 4'hf, 8'h00}};

  lsis_top lsis_top_i (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RX_PIN(rx), .EVT(evt), .PROTO_VECTOR(pvec),
    .LINK_CLK_EN(clk_en), .RUN_MODE(run), .IRQ(irq));
  lsis_lin_master lsis_lin_master_i (.clk(clk), .send(send), .rx_pin(rx), .busy());

  // ==================================================================
  // Tasks
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s: expected %h seen %h", n, e, s);
    end
  endtask
  // Write leaves the strobe up, so the following access or idle call must reassign it
  task automatic bus(logic r, logic [3:0] a, logic [7:0] d);
    rd <= r;
    wr <= !r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    if (r) begin
      rd <= 0;
      @(negedge clk) got = rdata;
      @(posedge clk);
    end
  endtask
  task automatic rchk(logic [3:0] a, logic [7:0] e);
    bus(1, a, 8'h00);
    check($sformatf("reg %h", a), got, e);
  endtask
  task automatic idle(int n);
    rd <= 0;
    wr <= 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic mode_chk(logic [7:0] e);
    @(negedge clk) check("mode outputs", {5'h0, clk_en, run, irq}, e);
    @(posedge clk);
  endtask
  task automatic wait_sts(logic [7:0] e);
    for (int i = 0; i < 30; i++) begin
      bus(1, LSIS_ADDR_STATUS, 8'h00);
      if (got === e)
        return;
    end
    check("status wait", got, e);
    stop_test();
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ==================================================================
  // Main sequence
  initial begin
    {reset, wr, rd, send, addr, wdata, evt} = {4'b1000, 4'h0, 8'h00, 3'b000};
    pvec = 8'h24;
    mode_chk(8'h00);
    @(posedge clk);
    reset <= 0;
    foreach (rows[i]) begin
      if (rows[i].r)
        rchk(rows[i].a, rows[i].d);
      else
        bus(0, rows[i].a, rows[i].d);
    end
    idle(1);
    mode_chk(8'h06);
    $display("test table done");
    // Break from the master, then an other-interrupt event and completions
    send <= 1;
    @(posedge clk);
    send <= 0;
    wait_sts(8'h80);
    rchk(LSIS_ADDR_EVT, 8'h01);
    mode_chk(8'h06);
    evt <= 3'b001;
    @(posedge clk);
    evt <= '0;
    mode_chk(8'h07);
    rchk(LSIS_ADDR_STATUS, 8'h81);
    rchk(LSIS_ADDR_VECTOR, 8'h24);
    bus(0, LSIS_ADDR_STATUS, 8'h7e);
    rchk(LSIS_ADDR_STATUS, 8'h81);
    bus(0, LSIS_ADDR_STATUS, 8'h01);
    rchk(LSIS_ADDR_STATUS, 8'h80);
    evt <= 3'b100;
    @(posedge clk);
    evt <= '0;
    rchk(LSIS_ADDR_STATUS, 8'h01);
    rchk(LSIS_ADDR_VECTOR, SV_RX_FULL);
    send <= 1;
    @(posedge clk);
    send <= 0;
    wait_sts(8'h81);
    // Flag clear and new source in the same cycle: source wins
    evt <= 3'b010;
    bus(0, LSIS_ADDR_STATUS, 8'h01);
    evt <= '0;
    rchk(LSIS_ADDR_STATUS, 8'h01);
    rchk(LSIS_ADDR_VECTOR, SV_TX_EMPTY);
    $display("test status done");
    // Software reset request, then system reset from disabled mode
    bus(0, LSIS_ADDR_CTRL, 8'h03);
    idle(2);
    mode_chk(8'h00);
    rchk(LSIS_ADDR_STATUS, 8'h20);
    rchk(LSIS_ADDR_CTRL, 8'h01);
    bus(0, LSIS_ADDR_CTRL, 8'h00);
    bus(0, LSIS_ADDR_CTRL, 8'h02);
    idle(1);
    mode_chk(8'h06);
    bus(0, LSIS_ADDR_CTRL, 8'h00);
    idle(1);
    mode_chk(8'h04);
    reset <= 1;
    mode_chk(8'h00);
    reset <= 0;
    rchk(LSIS_ADDR_CTRL, 8'h01);
    $display("test reset done");
    stop_test();
  end
endmodule
